/* cor_status_byte.sv */
// one clear-on-read status byte with sticky and loaded bits
`include "serdes_link_status_params.svh"

module cor_status_byte #(
  parameter logic [7:0] VALID_MASK = 8'hff
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // bit updates
  input  wire logic [7:0] set_bits,
  input  wire logic [7:0] load_mask,
  input  wire logic [7:0] load_val,
  input  wire logic       rd_clr,
  // stored value
  output logic      [7:0] q
);

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  // ----------------------------------------------------------------
  // update: clear first, so a same-cycle event survives the read
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = rd_clr ? `STATUS_RESET_VALUE : q_r;
    q_nxt = q_nxt | set_bits;
    q_nxt = (q_nxt & ~load_mask) | (load_val & load_mask);
    q_nxt = q_nxt & VALID_MASK;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= `STATUS_RESET_VALUE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : cor_status_byte

/* link_status_sva.sv */
// assertions on the register port of the serdes link status bank
`include "serdes_link_status_params.svh"
module link_status_sva (
  // clock and reset
  input wire logic                                       CORE_CLK,
  input wire logic                                       RST_B,
  // register port
  input wire logic [17:0]                                REG_ADDR,
  input wire logic                                       REG_RD,
  input wire logic                                       REG_WR,
  input wire logic [7:0]                                 REG_RDATA,
  input wire logic                                       REG_RVALID,
  // status sources
  input wire serdes_link_status_pkg::chan_status_type [3:0] CHAN_STATUS,
  input wire serdes_link_status_pkg::quad_event_type [1:0]  QUAD_EVENT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic rd;
  // a write riding with a read cancels the read
  assign rd = REG_RD && !REG_WR;
  property p_rvalid; rd |=> REG_RVALID; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_no_rvalid; !rd |=> !REG_RVALID; endproperty
  a_no_rvalid: assert property (p_no_rvalid) else $error("answer without read");
  property p_hold; !rd |=> $stable(REG_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_link_rsvd; rd && REG_ADDR[7:0] == 8'h04 |=> REG_RDATA[3:0] == 4'h0; endproperty
  a_link_rsvd: assert property (p_link_rsvd) else $error("link reserved bits set");
  property p_align_rsvd; rd && REG_ADDR[7:0] == 8'h05 |=> (REG_RDATA & 8'h33) == 8'h00; endproperty
  a_align_rsvd: assert property (p_align_rsvd) else $error("align reserved bits set");
  property p_pair_rsvd; rd && REG_ADDR[7:0] == 8'h14 |=> (REG_RDATA & 8'hed) == 8'h00; endproperty
  a_pair_rsvd: assert property (p_pair_rsvd) else $error("pair reserved bits set");
  property p_spare; rd && REG_ADDR == `QUAD_B_SPARE_CONTROL_ADDR |=> REG_RDATA == 8'h00; endproperty
  a_spare: assert property (p_spare) else $error("spare read not zero");
  property p_word_lock;
    rd && REG_ADDR == `QUAD_A_ALIGN_STATUS_ADDR && $past(RST_B) && $past(CHAN_STATUS[0].word_lock)
      |=> REG_RDATA[2];
  endproperty
  a_word_lock: assert property (p_word_lock) else $error("word lock lost");
  property p_ovfl;
    rd && REG_ADDR == `QUAD_A_PAIR_ALIGN_STATUS_ADDR && $past(RST_B)
      && $past(QUAD_EVENT[0].pair_align_fifo_overflow) |=> REG_RDATA[1];
  endproperty
  a_ovfl: assert property (p_ovfl) else $error("overflow lost");
  property p_lost;
    rd && REG_ADDR == `QUAD_B_PAIR_ALIGN_STATUS_ADDR && $past(RST_B)
      && $past(QUAD_EVENT[1].pair_align_lost) |=> REG_RDATA[4];
  endproperty
  a_lost: assert property (p_lost) else $error("sync loss lost");
endmodule : link_status_sva

/* serdes_link_status_params.svh */
// constants of the serdes link status register bank
`ifndef SERDES_LINK_STATUS_PARAMS_SVH
`define SERDES_LINK_STATUS_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses on the 18-bit register port
// ----------------------------------------------------------------
`define QUAD_A_LINK_STATE_ADDR        18'h30804
`define QUAD_A_ALIGN_STATUS_ADDR      18'h30805
`define QUAD_A_PAIR_ALIGN_STATUS_ADDR 18'h30814
`define QUAD_B_LINK_STATE_ADDR        18'h30904
`define QUAD_B_ALIGN_STATUS_ADDR      18'h30905
`define QUAD_B_PAIR_ALIGN_STATUS_ADDR 18'h30914
`define QUAD_B_SPARE_CONTROL_ADDR     18'h30933

// ----------------------------------------------------------------
// field positions, data bit n is printed bit n
// ----------------------------------------------------------------
`define LINK_SYNC_STATE_C_HI   4
`define LINK_SYNC_STATE_C_LO   5
`define LINK_SYNC_STATE_D_HI   6
`define LINK_SYNC_STATE_D_LO   7
`define WORD_LOCK_C_BIT        2
`define WORD_LOCK_D_BIT        3
`define LANE_DESKEW_DONE_C_BIT 6
`define LANE_DESKEW_DONE_D_BIT 7
`define PAIR_FIFO_OVERFLOW_BIT 1
`define PAIR_ALIGN_LOST_BIT    4

// ----------------------------------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------------------------------
`define LINK_STATE_MASK        8'hf0
`define ALIGN_STATUS_MASK      8'hcc
`define PAIR_ALIGN_MASK        8'h12
`define STATUS_RESET_VALUE     8'h00
`define LINK_NO_SYNC_CODE      2'b00

`endif

/* serdes_link_status_pkg.sv */
// types shared by the serdes link status register bank
package serdes_link_status_pkg;

  // ----------------------------------------------------------------
  // link state machine codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_NO_SYNC   = 2'b00,
    LINK_CV_NO_COMMA = 2'b01,
    LINK_SYNC_DONE = 2'b10,
    LINK_UNUSED    = 2'b11
  } link_code_type;

  // ----------------------------------------------------------------
  // live status of one channel and events of one quad
  // ----------------------------------------------------------------
  typedef struct packed {
    link_code_type link_sync_state;
    logic          word_lock;
    logic          lane_deskew_done;
  } chan_status_type;

  typedef struct packed {
    logic pair_align_fifo_overflow;
    logic pair_align_lost;
  } quad_event_type;

  // ----------------------------------------------------------------
  // register selector
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_A_LINK  = 3'h0,
    SEL_A_ALIGN = 3'h1,
    SEL_A_PAIR  = 3'h2,
    SEL_B_LINK  = 3'h3,
    SEL_B_ALIGN = 3'h4,
    SEL_B_PAIR  = 3'h5,
    SEL_NONE    = 3'h7
  } reg_sel_type;

endpackage : serdes_link_status_pkg

/* serdes_link_status_regs.sv */
// per-channel clear-on-read status registers of two transceiver quads
//
// Contract
// - status registers read-only, reading clears them
// - C channel link state at bits 4-5
// - D channel link state at bits 6-7
// - link state fields reset to no-sync
// - word lock bits 2 and 3, reset zero
// - deskew done bits 6 and 7, reset zero
// - pair fifo overflow flag bit 1
// - pair align lost flag bit 4
// - deskew reported only for enabled group members
// - link state used only when quad selects it
`include "serdes_link_status_params.svh"

module serdes_link_status_regs (
  // clock and reset
  input  wire logic                                        CORE_CLK,
  input  wire logic                                        RST_B,
  // register port
  input  wire logic                                 [17:0] REG_ADDR,
  input  wire logic                                        REG_RD,
  input  wire logic                                        REG_WR,
  input  wire logic                                  [7:0] REG_WDATA,
  output logic                                       [7:0] REG_RDATA,
  output logic                                             REG_RVALID,
  // live channel status, index 0 AC, 1 AD, 2 BC, 3 BD
  input  wire serdes_link_status_pkg::chan_status_type [3:0] CHAN_STATUS,
  // quad events, index 0 quad A, 1 quad B
  input  wire serdes_link_status_pkg::quad_event_type  [1:0] QUAD_EVENT,
  // control bits held outside this block
  input  wire logic                                  [3:0] DESKEW_MEMBER_EN,
  input  wire logic                                  [1:0] QUAD_LINK_SM_SELECT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic serdes_link_status_pkg::reg_sel_type decode_addr(input logic [17:0] addr);
    serdes_link_status_pkg::reg_sel_type sel;
    unique case (addr)
      `QUAD_A_LINK_STATE_ADDR:        sel = serdes_link_status_pkg::SEL_A_LINK;
      `QUAD_A_ALIGN_STATUS_ADDR:      sel = serdes_link_status_pkg::SEL_A_ALIGN;
      `QUAD_A_PAIR_ALIGN_STATUS_ADDR: sel = serdes_link_status_pkg::SEL_A_PAIR;
      `QUAD_B_LINK_STATE_ADDR:        sel = serdes_link_status_pkg::SEL_B_LINK;
      `QUAD_B_ALIGN_STATUS_ADDR:      sel = serdes_link_status_pkg::SEL_B_ALIGN;
      `QUAD_B_PAIR_ALIGN_STATUS_ADDR: sel = serdes_link_status_pkg::SEL_B_PAIR;
      default:                        sel = serdes_link_status_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decode_addr

  // printed bit hi carries the code msb
  function automatic logic [7:0] place_link_codes(input logic [1:0] code_c, input logic [1:0] code_d);
    logic [7:0] b;
    b = 8'h00;
    b[`LINK_SYNC_STATE_C_HI] = code_c[1];
    b[`LINK_SYNC_STATE_C_LO] = code_c[0];
    b[`LINK_SYNC_STATE_D_HI] = code_d[1];
    b[`LINK_SYNC_STATE_D_LO] = code_d[0];
    return b;
  endfunction : place_link_codes

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  serdes_link_status_pkg::reg_sel_type rd_sel;
  logic                          [5:0] rd_hit;
  logic                                rd_take;

  // writes are accepted and dropped: every location here is read-only
  assign rd_take = REG_RD & ~REG_WR;
  assign rd_sel  = decode_addr(REG_ADDR);

  always_comb begin
    rd_hit = 6'h00;
    if (rd_take && rd_sel != serdes_link_status_pkg::SEL_NONE) begin
      rd_hit[rd_sel] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // link state capture
  // ----------------------------------------------------------------
  logic [1:0] link_live [3:0];
  logic [1:0] link_seen_r [3:0];
  logic [3:0] link_change;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // the fibre-channel machine leaves the field at no-sync
      link_live[i]   = QUAD_LINK_SM_SELECT[i / 2] ? CHAN_STATUS[i].link_sync_state
                                                  : `LINK_NO_SYNC_CODE;
      link_change[i] = (link_live[i] != link_seen_r[i]);
    end
  end

  // a held state is reported again only after it changes, so a read really clears
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 4; i++) begin
        link_seen_r[i] <= `LINK_NO_SYNC_CODE;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        link_seen_r[i] <= link_live[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // status bytes
  // ----------------------------------------------------------------
  logic [7:0] link_q [1:0];
  logic [7:0] align_q [1:0];
  logic [7:0] pair_q [1:0];
  logic [7:0] link_mask [1:0];
  logic [7:0] link_val [1:0];
  logic [7:0] align_set [1:0];
  logic [7:0] pair_set [1:0];

  always_comb begin
    for (int q = 0; q < 2; q++) begin
      link_val[q]  = place_link_codes(link_live[2 * q], link_live[2 * q + 1]);
      link_mask[q] = place_link_codes({2{link_change[2 * q]}}, {2{link_change[2 * q + 1]}});
      align_set[q] = 8'h00;
      align_set[q][`WORD_LOCK_C_BIT] = CHAN_STATUS[2 * q].word_lock;
      align_set[q][`WORD_LOCK_D_BIT] = CHAN_STATUS[2 * q + 1].word_lock;
      align_set[q][`LANE_DESKEW_DONE_C_BIT] = CHAN_STATUS[2 * q].lane_deskew_done
                                              & DESKEW_MEMBER_EN[2 * q];
      align_set[q][`LANE_DESKEW_DONE_D_BIT] = CHAN_STATUS[2 * q + 1].lane_deskew_done
                                              & DESKEW_MEMBER_EN[2 * q + 1];
      pair_set[q] = 8'h00;
      pair_set[q][`PAIR_FIFO_OVERFLOW_BIT] = QUAD_EVENT[q].pair_align_fifo_overflow;
      pair_set[q][`PAIR_ALIGN_LOST_BIT]    = QUAD_EVENT[q].pair_align_lost;
    end
  end

  for (genvar q = 0; q < 2; q++) begin : g_quad
    cor_status_byte #(.VALID_MASK(`LINK_STATE_MASK)) u_link (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .set_bits  (8'h00),
      .load_mask (link_mask[q]),
      .load_val  (link_val[q]),
      .rd_clr    (rd_hit[3 * q]),
      .q         (link_q[q])
    );
    cor_status_byte #(.VALID_MASK(`ALIGN_STATUS_MASK)) u_align (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .set_bits  (align_set[q]),
      .load_mask (8'h00),
      .load_val  (8'h00),
      .rd_clr    (rd_hit[3 * q + 1]),
      .q         (align_q[q])
    );
    cor_status_byte #(.VALID_MASK(`PAIR_ALIGN_MASK)) u_pair (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .set_bits  (pair_set[q]),
      .load_mask (8'h00),
      .load_val  (8'h00),
      .rd_clr    (rd_hit[3 * q + 2]),
      .q         (pair_q[q])
    );
  end

  // ----------------------------------------------------------------
  // read data, registered; unmapped and spare locations read zero
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       rvalid_r;

  always_comb begin
    unique case (rd_sel)
      serdes_link_status_pkg::SEL_A_LINK:  rdata_nxt = link_q[0];
      serdes_link_status_pkg::SEL_A_ALIGN: rdata_nxt = align_q[0];
      serdes_link_status_pkg::SEL_A_PAIR:  rdata_nxt = pair_q[0];
      serdes_link_status_pkg::SEL_B_LINK:  rdata_nxt = link_q[1];
      serdes_link_status_pkg::SEL_B_ALIGN: rdata_nxt = align_q[1];
      serdes_link_status_pkg::SEL_B_PAIR:  rdata_nxt = pair_q[1];
      default:                             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd_take;
      if (rd_take) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign REG_RDATA  = rdata_r;
  assign REG_RVALID = rvalid_r;

endmodule : serdes_link_status_regs

/* tb.sv */
// self-checking bench of the serdes link status bank
`include "serdes_link_status_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [17:0] addr = 18'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  serdes_link_status_pkg::chan_status_type [3:0] chan = '0;
  serdes_link_status_pkg::quad_event_type [1:0] qev = '0;
  logic [3:0] member_en = 4'h0;
  logic [1:0] sm_sel = 2'h0;
  int err_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  serdes_link_status_regs DUT (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .CHAN_STATUS(chan), .QUAD_EVENT(qev),
    .DESKEW_MEMBER_EN(member_en), .QUAD_LINK_SM_SELECT(sm_sel));
  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic chk_rd(input logic [17:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    cmp_count++;
    if (rvalid !== 1'b1 || rdata !== exp) begin
      err_count++;
      $display("unexpected at %0t: addr %h read %h want %h", $time, a, rdata, exp);
    end
  endtask : chk_rd
  // a read riding with a write must go unanswered
  task automatic chk_quiet();
    cmp_count++;
    if (rvalid !== 1'b0) begin
      err_count++;
      $display("unexpected at %0t: answer to a read cancelled by a write", $time);
    end
  endtask : chk_quiet
  // printed bit 4 is the msb of the C code, bit 6 that of the D code
  function automatic logic [7:0] link_byte(input logic [1:0] c, input logic [1:0] d);
    return {d[0], d[1], c[0], c[1], 4'h0};
  endfunction : link_byte
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [17:0] a [8];
    a = '{`QUAD_A_LINK_STATE_ADDR, `QUAD_A_ALIGN_STATUS_ADDR, `QUAD_A_PAIR_ALIGN_STATUS_ADDR,
          `QUAD_B_LINK_STATE_ADDR, `QUAD_B_ALIGN_STATUS_ADDR, `QUAD_B_PAIR_ALIGN_STATUS_ADDR,
          `QUAD_B_SPARE_CONTROL_ADDR, 18'h30806};
    for (int i = 0; i < 8; i++) begin
      chk_rd(a[i], 8'h00);
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_link();
    logic [1:0] c;
    logic [1:0] d;
    sm_sel = 2'h3;
    for (int i = 1; i < 5; i++) begin
      c = 2'(i);
      d = 2'(i + 1);
      chan[0].link_sync_state = serdes_link_status_pkg::link_code_type'(c);
      chan[1].link_sync_state = serdes_link_status_pkg::link_code_type'(d);
      chan[2].link_sync_state = serdes_link_status_pkg::link_code_type'(c);
      chan[3].link_sync_state = serdes_link_status_pkg::link_code_type'(d);
      chk_rd(`QUAD_A_LINK_STATE_ADDR, link_byte(c, d));
      chk_rd(`QUAD_A_LINK_STATE_ADDR, 8'h00);
      chk_rd(`QUAD_B_LINK_STATE_ADDR, link_byte(c, d));
    end
    // quad A leaves link mode, quad B stays in it
    sm_sel = 2'h2;
    chan[0].link_sync_state = serdes_link_status_pkg::LINK_SYNC_DONE;
    chan[2].link_sync_state = serdes_link_status_pkg::LINK_SYNC_DONE;
    chk_rd(`QUAD_A_LINK_STATE_ADDR, 8'h00);
    chk_rd(`QUAD_B_LINK_STATE_ADDR, link_byte(2'h2, 2'h0));
    $display("test link done");
  endtask : t_link
  task automatic t_align();
    member_en = 4'h9;
    for (int i = 0; i < 4; i++) begin
      chan[i].word_lock = 1'b1;
      chan[i].lane_deskew_done = 1'b1;
    end
    repeat (2) begin
      chk_rd(`QUAD_A_ALIGN_STATUS_ADDR, 8'h4c);
      chk_rd(`QUAD_B_ALIGN_STATUS_ADDR, 8'h8c);
    end
    chan = '0;
    chk_rd(`QUAD_A_ALIGN_STATUS_ADDR, 8'h4c);
    @(negedge clk);
    rd = 1'b1;
    wr = 1'b1;
    wdata = 8'hff;
    addr = `QUAD_B_ALIGN_STATUS_ADDR;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    chk_quiet();
    chk_rd(`QUAD_B_ALIGN_STATUS_ADDR, 8'h8c);
    chk_rd(`QUAD_B_ALIGN_STATUS_ADDR, 8'h00);
    $display("test align done");
  endtask : t_align
  task automatic t_pair();
    @(negedge clk);
    qev[0].pair_align_fifo_overflow = 1'b1;
    qev[1].pair_align_lost = 1'b1;
    @(negedge clk);
    qev = '0;
    chk_rd(`QUAD_A_PAIR_ALIGN_STATUS_ADDR, 8'h02);
    chk_rd(`QUAD_B_PAIR_ALIGN_STATUS_ADDR, 8'h10);
    chk_rd(`QUAD_A_PAIR_ALIGN_STATUS_ADDR, 8'h00);
    chk_rd(`QUAD_B_SPARE_CONTROL_ADDR, 8'h00);
    $display("test pair done");
  endtask : t_pair
  task automatic t_mid_reset();
    chan[0].word_lock = 1'b1;
    chan[2].link_sync_state = serdes_link_status_pkg::LINK_SYNC_DONE;
    qev[1].pair_align_fifo_overflow = 1'b1;
    @(negedge clk);
    rst_b = 1'b0;
    chan = '0;
    qev = '0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk_rd(`QUAD_A_ALIGN_STATUS_ADDR, 8'h00);
    chk_rd(`QUAD_B_LINK_STATE_ADDR, 8'h00);
    chk_rd(`QUAD_B_PAIR_ALIGN_STATUS_ADDR, 8'h00);
    $display("test mid reset done");
  endtask : t_mid_reset
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_link();
    t_align();
    t_pair();
    t_mid_reset();
    tally_and_finish();
  end
  // the run needs under a hundred cycles, so this only trips on a hang
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule : tb
bind serdes_link_status_regs link_status_sva u_sva (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
  .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .CHAN_STATUS(CHAN_STATUS), .QUAD_EVENT(QUAD_EVENT));
